// file: verilog/mlsi_pkg.sv
/*
 * Shared constants and types of the lane interface: word layout, delay taps,
 * receive queue depth, controller register map and field positions.
 * Assumes every file of the lane and controller imports it whole.
 */
package mlsi_pkg;

	// ------------------------------------------------------------
	// Lane data path
	// ------------------------------------------------------------
	localparam int         WORD_W        = 8;
	localparam int         BITS_PER_WORD = 8;
	localparam int         DELAY_W       = 3;
	localparam logic [2:0] DELAY_INIT    = 3'h0;
	localparam logic [2:0] DELAY_MAX     = 3'h7;
	localparam int         QUEUE_DEPTH   = 4;
	localparam logic [7:0] SYNC_WORD     = 8'hb8;

	// ------------------------------------------------------------
	// Controller registers (byte addresses)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_TXDATA = 8'h04;
	localparam logic [7:0] OFS_RXDATA = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_DELAY  = 8'h10;

	localparam int CTRL_BUF_EN  = 0;
	localparam int CTRL_TERM_EN = 1;
	localparam int CTRL_FAST_DRIVE_EN   = 2;
	localparam int CTRL_LPP_OE  = 3;
	localparam int CTRL_LPN_OE  = 4;
	localparam int CTRL_LPP_OUT = 5;
	localparam int CTRL_LPN_OUT = 6;
	localparam int CTRL_RX_RST  = 7;
	localparam int CTRL_TX_RST  = 8;
	localparam int CTRL_REHUNT  = 9;
	localparam int CTRL_W       = 9;
	localparam logic [8:0] CTRL_RESET = 9'h000;

	localparam int STAT_RX_VALID = 0;
	localparam int STAT_LOCKED   = 1;
	localparam int STAT_LPP_IN   = 2;
	localparam int STAT_LPN_IN   = 3;
	localparam int STAT_OVERRUN  = 4;

	localparam int DLY_DIR   = 0;
	localparam int DLY_CLEAR = 1;

	typedef enum {
		MLSI_HUNT,
		MLSI_LOCKED
	} mlsi_align_t;

endpackage

// file: verilog/mlsi_lane_if.sv
/*
 * Fabric-side signals between the lane and its controller.
 * Assumes both ends run on the same system clock; word timing is carried
 * by the word clock feed pulse.
 */
`timescale 1ns/100ps
interface mlsi_lane_if;
	import mlsi_pkg::*;

	logic [WORD_W-1:0] fast_rx_word;
	logic              queue_empty;
	logic              queue_read_en;
	logic              lowpower_pos_level_in;
	logic              lowpower_neg_level_in;
	logic              lowpower_pos_level_out;
	logic              lowpower_neg_level_out;
	logic              lowpower_pos_drive_en;
	logic              lowpower_neg_drive_en;
	logic [WORD_W-1:0] fast_tx_word;
	logic              fast_drive_en;
	logic              fast_input_buffer_en;
	logic              fast_termination_en;
	logic              delay_adjust_en;
	logic              delay_direction;
	logic              delay_counter_clear;
	logic              rx_reset;
	logic              tx_reset;
	logic              lane_word_clock_feed;
	logic              lane_bit_clock_feed;
	logic              lane_core_clock_feed;

	modport lane (
		output fast_rx_word, queue_empty, lowpower_pos_level_in, lowpower_neg_level_in,
		output lane_word_clock_feed, lane_bit_clock_feed, lane_core_clock_feed,
		input  queue_read_en, lowpower_pos_level_out, lowpower_neg_level_out,
		input  lowpower_pos_drive_en, lowpower_neg_drive_en, fast_tx_word, fast_drive_en,
		input  fast_input_buffer_en, fast_termination_en, delay_adjust_en,
		input  delay_direction, delay_counter_clear, rx_reset, tx_reset
	);

	modport ctrl (
		input  fast_rx_word, queue_empty, lowpower_pos_level_in, lowpower_neg_level_in,
		input  lane_word_clock_feed, lane_bit_clock_feed, lane_core_clock_feed,
		output queue_read_en, lowpower_pos_level_out, lowpower_neg_level_out,
		output lowpower_pos_drive_en, lowpower_neg_drive_en, fast_tx_word, fast_drive_en,
		output fast_input_buffer_en, fast_termination_en, delay_adjust_en,
		output delay_direction, delay_counter_clear, rx_reset, tx_reset
	);

endinterface

// file: verilog/mlsi_word_clock.sv
/*
 * Clock lane divider: bit clock feed, one-cycle word strobe and a
 * square core clock feed at word rate, all from the system clock.
 * Assumes one system clock cycle stands for one serial bit time.
 */
`timescale 1ns/100ps
module mlsi_word_clock
	import mlsi_pkg::*;
#(
	parameter int BITS = BITS_PER_WORD
) (
	// Clock and reset
	input  wire logic clk_sys_i,
	input  wire logic sys_rst_i,
	// Clock feeds
	output logic      word_strobe_o,
	output logic      bit_clock_o,
	output logic      core_clock_o
);

	localparam int CW = $clog2(BITS);
	localparam logic [CW-1:0] LAST = CW'(BITS - 1);
	localparam logic [CW-1:0] HALF = CW'(BITS / 2);

	logic [CW-1:0] count;

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			count <= '0;
		end else if (count == LAST) begin
			count <= '0;
		end else begin
			count <= count + 1'b1;
		end
	end

	// Strobe lands in the cycle where count sits at its last value
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			word_strobe_o <= 1'b0;
			bit_clock_o   <= 1'b0;
			core_clock_o  <= 1'b0;
		end else begin
			word_strobe_o <= (count == LAST - 1'b1);
			bit_clock_o   <= ~bit_clock_o;
			core_clock_o  <= (count < HALF);
		end
	end

endmodule

// file: verilog/mlsi_lane.sv
/*
 * Lane end: deserialiser with input delay taps and optional receive
 * queue, serialiser, low-power pad paths and pad enables.
 * Assumes the pads are resolved outside from the output enables, and that
 * one system clock cycle is one serial bit time.
 */
// What this block does
// - Received words leave as 8 bits, word-timed
// - Low-power pad levels pass straight to fabric
// - Fabric drives low-power levels on reversible lane
// - Queue empty flag tracks an empty queue
// - Fabric pulses read enable to pop words
// - Receive reset clears queue and deserialiser asynchronously
// - Input buffer works only while enabled
// - Termination follows its control input
// - Delay steps only while adjust enable set
// - Direction one increments, zero decrements delay
// - Delay clear restores initial tap
// - Clock lane makes bit and word clocks
// - Core clock feed is output only; fabric and queue reads run on the system clock
// - Transmit clocks come from the clock source
// - Fabric supplies fixed 8-bit transmit words
// - Serial output drives only while enabled
// - Each pad's low-power drive has own enable
// - Transmit reset clears the serialiser
// - Reversible lane returns low-power levels
// - Eight-fold serdes fast, none in low-power
`timescale 1ns/100ps
module mlsi_lane
	import mlsi_pkg::*;
#(
	parameter bit QUEUE_EN   = 1'b1,
	parameter int QDEPTH     = QUEUE_DEPTH,
	parameter bit REVERSIBLE = 1'b1
) (
	// Clock and reset
	input  wire logic               clk_sys_i,
	input  wire logic               sys_rst_i,
	// Fabric side
	mlsi_lane_if.lane               lane,
	// Pads
	input  wire logic               pad_p_i,
	input  wire logic               pad_n_i,
	output logic                    pad_p_o,
	output logic                    pad_p_oe_o,
	output logic                    pad_n_o,
	output logic                    pad_n_oe_o,
	// Analog controls and status
	output logic                    input_buffer_on_o,
	output logic                    termination_on_o,
	output logic [DELAY_W-1:0]      delay_tap_o
);

	localparam int QW = $clog2(QDEPTH);

	// ------------------------------------------------------------
	// Clock lane
	// ------------------------------------------------------------
	logic word_strobe;

	// One divider serves receive and transmit; stands in for the PLL
	mlsi_word_clock #(
		.BITS          (BITS_PER_WORD)
	) u_clock (
		.clk_sys_i     (clk_sys_i),
		.sys_rst_i     (sys_rst_i),
		.word_strobe_o (word_strobe),
		.bit_clock_o   (lane.lane_bit_clock_feed),
		.core_clock_o  (lane.lane_core_clock_feed)
	);

	assign lane.lane_word_clock_feed = word_strobe;

	// ------------------------------------------------------------
	// Analog controls
	// ------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			input_buffer_on_o <= 1'b0;
			termination_on_o  <= 1'b0;
		end else begin
			input_buffer_on_o <= lane.fast_input_buffer_en;
			termination_on_o  <= lane.fast_termination_en;
		end
	end

	// ------------------------------------------------------------
	// Low-power levels
	// ------------------------------------------------------------
	// Registered once; no clock relation is promised to the fabric
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			lane.lowpower_pos_level_in <= 1'b0;
			lane.lowpower_neg_level_in <= 1'b0;
		end else if (REVERSIBLE) begin
			lane.lowpower_pos_level_in <= pad_p_i;
			lane.lowpower_neg_level_in <= pad_n_i;
		end
	end

	// ------------------------------------------------------------
	// Input delay taps
	// ------------------------------------------------------------
	// Adjusted once per word, in the word clock domain
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			delay_tap_o <= DELAY_INIT;
		end else if (word_strobe && lane.delay_counter_clear) begin
			delay_tap_o <= DELAY_INIT;
		end else if (word_strobe && lane.delay_adjust_en) begin
			if (lane.delay_direction && delay_tap_o != DELAY_MAX) begin
				delay_tap_o <= delay_tap_o + 1'b1;
			end else if (!lane.delay_direction && delay_tap_o != '0) begin
				delay_tap_o <= delay_tap_o - 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Deserialiser
	// ------------------------------------------------------------
	logic [DELAY_MAX:0]  bit_history;
	logic [WORD_W-2:0]   rx_shift;
	logic [WORD_W-1:0]   rx_word;
	logic                rx_word_ready;
	logic                rx_bit;
	logic                diff_bit;

	// Disabled buffer reads as a steady zero stream
	assign diff_bit = input_buffer_on_o & pad_p_i & ~pad_n_i;
	assign rx_bit   = bit_history[delay_tap_o];

	// Receive reset acts without the clock
	always_ff @(posedge clk_sys_i or posedge lane.rx_reset) begin
		if (lane.rx_reset) begin
			bit_history   <= '0;
			rx_shift      <= '0;
			rx_word       <= '0;
			rx_word_ready <= 1'b0;
		end else if (sys_rst_i) begin
			bit_history   <= '0;
			rx_shift      <= '0;
			rx_word       <= '0;
			rx_word_ready <= 1'b0;
		end else begin
			bit_history   <= {bit_history[DELAY_MAX-1:0], diff_bit};
			rx_shift      <= {rx_shift[WORD_W-3:0], rx_bit};
			rx_word_ready <= word_strobe;
			if (word_strobe) begin
				rx_word <= {rx_shift, rx_bit};
			end
		end
	end

	// ------------------------------------------------------------
	// Receive queue
	// ------------------------------------------------------------
	logic [WORD_W-1:0] queue_mem [QDEPTH];
	logic [QW-1:0]     wr_ptr;
	logic [QW-1:0]     rd_ptr;
	logic [QW:0]       fill;
	logic [QW:0]       next_fill;
	logic              push;
	logic              pop;

	// Words arriving on a full queue are dropped; no alignment here
	assign push = QUEUE_EN && rx_word_ready && (fill != (QW+1)'(QDEPTH));
	assign pop  = QUEUE_EN && lane.queue_read_en && (fill != '0);

	always_comb begin
		next_fill = fill;
		if (push && !pop) begin
			next_fill = fill + 1'b1;
		end else if (pop && !push) begin
			next_fill = fill - 1'b1;
		end
	end

	always_ff @(posedge clk_sys_i or posedge lane.rx_reset) begin
		if (lane.rx_reset) begin
			wr_ptr           <= '0;
			rd_ptr           <= '0;
			fill             <= '0;
			lane.queue_empty <= 1'b1;
		end else if (sys_rst_i) begin
			wr_ptr           <= '0;
			rd_ptr           <= '0;
			fill             <= '0;
			lane.queue_empty <= 1'b1;
		end else begin
			fill             <= next_fill;
			lane.queue_empty <= (next_fill == '0);
			if (push) begin
				wr_ptr <= (wr_ptr == QW'(QDEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == QW'(QDEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (push) begin
			queue_mem[wr_ptr] <= rx_word;
		end
	end

	// Popped word appears the cycle after the read enable
	always_ff @(posedge clk_sys_i or posedge lane.rx_reset) begin
		if (lane.rx_reset) begin
			lane.fast_rx_word <= '0;
		end else if (sys_rst_i) begin
			lane.fast_rx_word <= '0;
		end else if (QUEUE_EN) begin
			if (pop) begin
				lane.fast_rx_word <= queue_mem[rd_ptr];
			end
		end else if (rx_word_ready) begin
			lane.fast_rx_word <= rx_word;
		end
	end

	// ------------------------------------------------------------
	// Serialiser and pad drive
	// ------------------------------------------------------------
	logic [WORD_W-1:0] tx_shift;

	// Word is taken whole at the strobe, most significant bit first
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || lane.tx_reset) begin
			tx_shift <= '0;
		end else if (word_strobe) begin
			tx_shift <= lane.fast_tx_word;
		end else begin
			tx_shift <= {tx_shift[WORD_W-2:0], 1'b0};
		end
	end

	// Fast drive wins over low-power drive when both are asked for
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pad_p_o    <= 1'b0;
			pad_n_o    <= 1'b0;
			pad_p_oe_o <= 1'b0;
			pad_n_oe_o <= 1'b0;
		end else if (lane.fast_drive_en) begin
			pad_p_o    <= tx_shift[WORD_W-1];
			pad_n_o    <= ~tx_shift[WORD_W-1];
			pad_p_oe_o <= 1'b1;
			pad_n_oe_o <= 1'b1;
		end else begin
			pad_p_o    <= lane.lowpower_pos_level_out;
			pad_n_o    <= lane.lowpower_neg_level_out;
			pad_p_oe_o <= lane.lowpower_pos_drive_en;
			pad_n_oe_o <= lane.lowpower_neg_drive_en;
		end
	end

endmodule

// file: verilog/mlsi_ctrl.sv
/*
 * Controller end: APB registers steering the lane, receive word capture
 * and byte alignment on a sync word, low-power drive and delay requests.
 * Assumes an APB master on the system clock and the lane on the interface.
 */
`timescale 1ns/100ps
module mlsi_ctrl
	import mlsi_pkg::*;
#(
	parameter bit QUEUE_EN = 1'b1
) (
	// Clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        sys_rst_i,
	// Lane side
	mlsi_lane_if.ctrl        lane,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o
);

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	logic [CTRL_W:0] ctrl;
	logic [7:0]      rx_data;
	logic            rx_valid;
	logic            overrun;
	logic            locked;
	logic            setup;
	logic            access;
	logic            mapped;

	assign setup  = psel_i && !penable_i;
	assign access = psel_i && penable_i && pready_o;
	assign mapped = paddr_i == OFS_CTRL || paddr_i == OFS_TXDATA ||
		paddr_i == OFS_RXDATA || paddr_i == OFS_STATUS || paddr_i == OFS_DELAY;

	// Zero wait states: read data is latched in the setup cycle
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			prdata_o  <= '0;
			pready_o  <= 1'b0;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= 1'b1;
			if (setup) begin
				pslverr_o <= !mapped;
				case (paddr_i)
					OFS_CTRL:   prdata_o <= 32'(ctrl);
					OFS_TXDATA: prdata_o <= 32'(lane.fast_tx_word);
					OFS_RXDATA: prdata_o <= 32'(rx_data);
					OFS_STATUS: prdata_o <= 32'({overrun, lane.lowpower_neg_level_in,
						lane.lowpower_pos_level_in, locked, rx_valid});
					default:    prdata_o <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ctrl              <= {1'b0, CTRL_RESET};
			lane.fast_tx_word <= '0;
		end else if (access && pwrite_i) begin
			if (paddr_i == OFS_CTRL) begin
				ctrl <= pwdata_i[CTRL_W:0];
			end
			if (paddr_i == OFS_TXDATA) begin
				lane.fast_tx_word <= pwdata_i[WORD_W-1:0];
			end
		end else begin
			ctrl[CTRL_REHUNT] <= 1'b0;
		end
	end

	assign lane.fast_input_buffer_en   = ctrl[CTRL_BUF_EN];
	assign lane.fast_termination_en    = ctrl[CTRL_TERM_EN];
	assign lane.fast_drive_en          = ctrl[CTRL_FAST_DRIVE_EN];
	assign lane.lowpower_pos_drive_en  = ctrl[CTRL_LPP_OE];
	assign lane.lowpower_neg_drive_en  = ctrl[CTRL_LPN_OE];
	assign lane.lowpower_pos_level_out = ctrl[CTRL_LPP_OUT];
	assign lane.lowpower_neg_level_out = ctrl[CTRL_LPN_OUT];
	assign lane.rx_reset               = ctrl[CTRL_RX_RST];
	assign lane.tx_reset               = ctrl[CTRL_TX_RST];

	// ------------------------------------------------------------
	// Delay requests
	// ------------------------------------------------------------
	// Held until the lane samples them at the next word strobe
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			lane.delay_adjust_en     <= 1'b0;
			lane.delay_direction     <= 1'b0;
			lane.delay_counter_clear <= 1'b0;
		end else if (access && pwrite_i && paddr_i == OFS_DELAY) begin
			lane.delay_adjust_en     <= !pwdata_i[DLY_CLEAR];
			lane.delay_direction     <= pwdata_i[DLY_DIR];
			lane.delay_counter_clear <= pwdata_i[DLY_CLEAR];
		end else if (lane.lane_word_clock_feed) begin
			lane.delay_adjust_en     <= 1'b0;
			lane.delay_counter_clear <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Word capture and alignment
	// ------------------------------------------------------------
	logic              took;
	logic [7:0]        prev_word;
	logic [15:0]       window;
	logic [15:0]       shifted;
	logic [2:0]        offset;
	logic [2:0]        hit_ofs;
	logic              hit;
	mlsi_align_t       align_state;

	// Pop taken on the same condition the lane uses
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			lane.queue_read_en <= 1'b0;
			took               <= 1'b0;
		end else if (QUEUE_EN) begin
			lane.queue_read_en <= !lane.queue_empty;
			took               <= lane.queue_read_en && !lane.queue_empty;
		end else begin
			lane.queue_read_en <= 1'b0;
			took               <= lane.lane_word_clock_feed;
		end
	end

	assign window  = {prev_word, lane.fast_rx_word};
	assign shifted = window << offset;

	always_comb begin
		hit     = 1'b0;
		hit_ofs = '0;
		for (int k = BITS_PER_WORD - 1; k >= 0; k--) begin
			if (window[15-k -: 8] == SYNC_WORD) begin
				hit     = 1'b1;
				hit_ofs = 3'(k);
			end
		end
	end

	assign locked = (align_state == MLSI_LOCKED);

	// Bytes are aligned here; the lane delivers raw words
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i || ctrl[CTRL_REHUNT]) begin
			align_state <= MLSI_HUNT;
			offset      <= '0;
			prev_word   <= '0;
		end else if (took) begin
			prev_word <= lane.fast_rx_word;
			case (align_state)
				MLSI_HUNT: begin
					if (hit) begin
						align_state <= MLSI_LOCKED;
						offset      <= hit_ofs;
					end
				end
				MLSI_LOCKED: begin
					align_state <= MLSI_LOCKED;
				end
				default: begin
					align_state <= MLSI_HUNT;
				end
			endcase
		end
	end

	// New word wins over a read of the data register in the same cycle
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			rx_data  <= '0;
			rx_valid <= 1'b0;
			overrun  <= 1'b0;
		end else if (took && locked) begin
			rx_data  <= shifted[15:8];
			rx_valid <= 1'b1;
			overrun  <= overrun | rx_valid;
		end else if (access && !pwrite_i && paddr_i == OFS_RXDATA) begin
			rx_valid <= 1'b0;
			overrun  <= 1'b0;
		end
	end

endmodule

// file: verification/mlsi_assertions.sv
/*
 * Checker of the lane interface: clock feeds, queue flags, receive reset,
 * low-power return path and delay requests.
 * Assumes instantiation beside the interface, on the system clock.
 */
`timescale 1ns/100ps
module mlsi_checker (
	// Clock and reset
	input wire logic       clk_sys_i,
	input wire logic       sys_rst_i,
	// Interface signals
	input wire logic [7:0] fast_rx_word,
	input wire logic       queue_empty,
	input wire logic       queue_read_en,
	input wire logic       lowpower_pos_level_in,
	input wire logic       lowpower_pos_level_out,
	input wire logic       lowpower_pos_drive_en,
	input wire logic       fast_drive_en,
	input wire logic       delay_adjust_en,
	input wire logic       rx_reset,
	input wire logic       lane_word_clock_feed,
	input wire logic       lane_bit_clock_feed,
	input wire logic       lane_core_clock_feed
);
	// ------
	// Properties
	// ------
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (sys_rst_i);

	property p_word;
		lane_word_clock_feed |=> !lane_word_clock_feed [*7] ##1 lane_word_clock_feed;
	endproperty
	a_word: assert property (p_word) else $error("strobe period");
	property p_bit;
		1'h1 |=> $changed(lane_bit_clock_feed);
	endproperty
	a_bit: assert property (p_bit) else $error("bit clock stuck");
	property p_core;
		$rose(lane_core_clock_feed) |-> lane_core_clock_feed [*4] ##1 !lane_core_clock_feed [*4];
	endproperty
	a_core: assert property (p_core) else $error("core clock shape");
	property p_rxrst;
		rx_reset |-> queue_empty && fast_rx_word == 8'h0;
	endproperty
	a_rxrst: assert property (p_rxrst) else $error("receive reset");
	property p_fill;
		$fell(queue_empty) |-> $past(lane_word_clock_feed, 2);
	endproperty
	a_fill: assert property (p_fill) else $error("empty fell early");
	property p_drain;
		$rose(queue_empty) |-> $past(queue_read_en) || $past(queue_read_en, 2) || rx_reset;
	endproperty
	a_drain: assert property (p_drain) else $error("empty rose alone");
	// Pad flop then level flop: two cycles from fabric level to return level
	property p_lpp;
		(lowpower_pos_drive_en && !fast_drive_en) [*3]
			|-> lowpower_pos_level_in == $past(lowpower_pos_level_out, 2);
	endproperty
	a_lpp: assert property (p_lpp) else $error("lp return level");
	property p_dly;
		$fell(delay_adjust_en) |-> $past(lane_word_clock_feed);
	endproperty
	a_dly: assert property (p_dly) else $error("delay request span");
endmodule

// file: verification/tb_mipi_lane_serdes_interface.sv
/*
 * Bench joining lane and controller: APB master, serial pad source and a
 * monitor comparing results with queued expectations.
 * Assumes one system clock and a synchronous reset.
 */
`timescale 1ns/100ps
module tb_mipi_lane_serdes_interface;
	import mlsi_pkg::*;
	logic        clk_sys_i = 1'h0, sys_rst_i = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
	logic [7:0]  padr = 8'h0, sr = SYNC_WORD, d = 8'h0, tp = 8'h0, tn = 8'h0;
	logic [31:0] pwd = 32'h0, prd, lf = 32'h14d1f;
	logic        rdy, err, pp, pn, ppo, pno, ppe, pne, ibuf, term;
	logic        bp = 1'h1, bn = 1'h1, rx_on = 1'h0, smp = 1'h0, tx_chk = 1'h0;
	logic [2:0]  tap, bc = 3'h0;
	logic [3:0]  cnt = 4'h0;
	logic [32:0] q[$], m[$];
	int          miscompares = 0, check_count = 0;

	mlsi_lane_if lif ();
	mlsi_lane mlsi_lane_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .lane(lif),
		.pad_p_i(pp), .pad_n_i(pn), .pad_p_o(ppo), .pad_p_oe_o(ppe), .pad_n_o(pno),
		.pad_n_oe_o(pne), .input_buffer_on_o(ibuf), .termination_on_o(term), .delay_tap_o(tap));
	mlsi_ctrl mlsi_ctrl_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .lane(lif),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd),
		.prdata_o(prd), .pready_o(rdy), .pslverr_o(err));
	mlsi_checker mlsi_checker_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
		.fast_rx_word(lif.fast_rx_word), .queue_empty(lif.queue_empty),
		.queue_read_en(lif.queue_read_en), .lowpower_pos_level_in(lif.lowpower_pos_level_in),
		.lowpower_pos_level_out(lif.lowpower_pos_level_out),
		.lowpower_pos_drive_en(lif.lowpower_pos_drive_en), .fast_drive_en(lif.fast_drive_en),
		.delay_adjust_en(lif.delay_adjust_en), .rx_reset(lif.rx_reset),
		.lane_word_clock_feed(lif.lane_word_clock_feed),
		.lane_bit_clock_feed(lif.lane_bit_clock_feed),
		.lane_core_clock_feed(lif.lane_core_clock_feed));

	always #50 clk_sys_i = ~clk_sys_i;
	// Undriven pads show the far side's level, never the lane's last value
	assign pp = ppe ? ppo : bp;
	assign pn = pne ? pno : bn;

	// ------
	// Tasks
	// ------
	function automatic logic [31:0] nx(logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic stop_test();
		$display("checks %0d miscompares %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic got(logic [32:0] v);
		logic [32:0] e, k;
		e = q.size() ? q.pop_front() : 'x;
		k = m.size() ? m.pop_front() : '1;
		check_count++;
		if ((v & k) !== (e & k)) begin
			miscompares++;
			$display("MISMATCH %0t got %h exp %h", $time, v, e);
		end
	endtask
	task automatic note(logic [32:0] e, logic [32:0] k = '1);
		q.push_back(e);
		m.push_back(k);
	endtask
	task automatic tick(int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] v);
		int n;
		tick(1);
		psel <= 1'h1;
		pwr <= w;
		padr <= a;
		pwd <= v;
		tick(1);
		pen <= 1'h1;
		n = 0;
		do begin
			tick(1);
			n++;
		end while (rdy !== 1'h1 && n < 20);
		psel <= 1'h0;
		pen <= 1'h0;
		if (rdy !== 1'h1) begin
			miscompares++;
			stop_test();
		end
	endtask
	task automatic rd(logic [7:0] a, logic [32:0] e, logic [32:0] k = '1);
		note(e, k);
		apb(1'h0, a, 32'h0);
	endtask
	task automatic look(logic [6:0] e);
		note({26'h0, e});
		tick(3);
		smp <= 1'h1;
		tick(1);
		smp <= 1'h0;
	endtask
	// Two serialised words checked, aligned on the word strobe
	task automatic txq(logic [15:0] e);
		tick(20);
		note({17'h0, e});
		note({17'h0, e});
		tx_chk <= 1'h1;
		for (int i = 0; i < 40 && q.size(); i++)
			tick(1);
		tx_chk <= 1'h0;
		if (q.size()) begin
			miscompares++;
			stop_test();
		end
	endtask
	// One delay step per request; ten cycles lets each strobe pass
	task automatic dly(logic [31:0] v, int n, logic [2:0] t);
		repeat (n) begin
			apb(1'h1, OFS_DELAY, v);
			tick(10);
		end
		look({2'h0, t, 2'h0});
	endtask

	always @(posedge clk_sys_i) begin
		if (psel && pen && rdy === 1'h1 && !pwr)
			got({err, prd});
		if (smp)
			got({26'h0, pne, ppe, tap, term, ibuf});
		if (tx_chk && cnt == 4'h1)
			got({17'h0, tn, tp});
		cnt <= lif.lane_word_clock_feed ? 4'h0 : cnt + 4'h1;
		tp <= {tp[6:0], ppo};
		tn <= {tn[6:0], pno};
	end
	// Idle source rearms on the sync word, so one process owns the pads
	always @(posedge clk_sys_i) begin
		if (rx_on) begin
			bp <= sr[7];
			bn <= ~sr[7];
			sr <= bc == 3'h7 ? d : sr << 1;
			bc <= bc + 3'h1;
		end else begin
			bp <= 1'h1;
			bn <= 1'h1;
			sr <= SYNC_WORD;
			bc <= 3'h0;
		end
	end

	// ------
	// Sequence
	// ------
	initial begin
		logic [32:0] e;
		tick(4);
		sys_rst_i <= 1'h0;
		rd(OFS_CTRL, 33'h0);
		rd(OFS_STATUS, 33'hc);
		rd(8'h14, 33'h100000000);
		look(7'h0);
		for (int i = 0; i < 6; i++) begin
			lf = nx(lf);
			apb(1'h1, OFS_CTRL, {25'h0, lf[1:0], lf[3:2], 3'h0});
			tick(4);
			e = {29'h0, lf[3] ? lf[1] : 1'h1, lf[2] ? lf[0] : 1'h1, 2'h0};
			rd(OFS_STATUS, e, 33'hc);
		end
		apb(1'h1, OFS_CTRL, 32'h6);
		look(7'h62);
		lf = nx(lf);
		apb(1'h1, OFS_TXDATA, {24'h0, lf[7:0]});
		txq({~lf[7:0], lf[7:0]});
		apb(1'h1, OFS_CTRL, 32'h106);
		txq(16'hff00);
		apb(1'h1, OFS_CTRL, 32'h0);
		dly(32'h1, 9, 3'h7);
		dly(32'h0, 2, 3'h5);
		dly(32'h3, 1, 3'h0);
		dly(32'h0, 1, 3'h0);
		lf = nx(lf);
		d <= lf[7:0];
		rx_on <= 1'h1;
		tick(40);
		rd(OFS_STATUS, 33'h0, 33'h3);
		rx_on <= 1'h0;
		tick(1);
		apb(1'h1, OFS_CTRL, 32'h1);
		rx_on <= 1'h1;
		tick(60);
		rd(OFS_STATUS, 33'h3, 33'h3);
		rd(OFS_RXDATA, {25'h0, d});
		apb(1'h1, OFS_CTRL, 32'h201);
		rd(OFS_STATUS, 33'h0, 33'h2);
		apb(1'h1, OFS_CTRL, 32'h81);
		tick(4);
		apb(1'h1, OFS_CTRL, 32'h1);
		stop_test();
	end
endmodule
